// ### rtl/agc_regs_defines.svh
// Purpose: constants for the record-path gain control register bank
// Assumes: byte offsets on a 32-bit classic Wishbone port
// Notes: definitions only
`ifndef AGC_REGS_DEFINES_SVH
`define AGC_REGS_DEFINES_SVH
// =====================================================
// register indices; byte address is four times these
`define LEFT_GAIN_IDX 8'h5d
`define RIGHT_FIRST_IDX 8'h5e
`define RIGHT_SECOND_IDX 8'h5f
// =====================================================
// field positions
`define ENABLE_BIT 7
`define TARGET_MSB 6
`define TARGET_LSB 4
`define GAIN_HYST_MSB 1
`define GAIN_HYST_LSB 0
`define HYST_MSB 7
`define HYST_LSB 6
`define NOISE_MSB 5
`define NOISE_LSB 1
// =====================================================
// reset values
`define LEFT_GAIN_RESET 8'h00
`define RIGHT_FIRST_RESET 8'h00
`define RIGHT_SECOND_RESET 8'h00
// writable masks; reserved bits read zero
`define RIGHT_FIRST_MASK 8'hf3
`define RIGHT_SECOND_MASK 8'hfe
// gain code limits, 0.5 dB steps
`define GAIN_MIN_CODE 8'he8
`define GAIN_MAX_CODE 8'h74
`endif

// ### rtl/agc_regs_pkg.sv
// Purpose: types for the gain control register bank
// Assumes: nothing
// Notes: constants live in the defines header
package agc_regs_pkg;
  // =====================================================
  // decoded right-channel settings
  typedef struct packed {
    logic enable;
    logic [2:0] target_code;
    logic [1:0] gain_hyst_code;
    logic [1:0] hyst_code;
    logic [4:0] noise_code;
  } right_settings_type;
  // target level in units of -0.5 dBFS
  typedef struct packed {
    logic [5:0] target_half_db;
    logic [1:0] gain_hyst_half_db;
    logic [3:0] hyst_half_db;
    logic hyst_on;
    logic noise_gate_on;
    logic [7:0] noise_neg_db;
  } right_decoded_type;
endpackage : agc_regs_pkg

// ### rtl/agc_setting_decode.sv
// Purpose: turns right-channel codes into physical levels
// Assumes: codes come from the register bank
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
module agc_setting_decode
  import agc_regs_pkg::*;
(
  input wire right_settings_type settings,
  output right_decoded_type decoded
);
  // =====================================================
  // decode
  always_comb begin
    decoded = '0;
    case (settings.target_code)
      3'h0: decoded.target_half_db = 6'h0b;
      3'h1: decoded.target_half_db = 6'h10;
      3'h2: decoded.target_half_db = 6'h14;
      3'h3: decoded.target_half_db = 6'h18;
      3'h4: decoded.target_half_db = 6'h1c;
      3'h5: decoded.target_half_db = 6'h22;
      3'h6: decoded.target_half_db = 6'h28;
      default: decoded.target_half_db = 6'h30;
    endcase
    decoded.gain_hyst_half_db = settings.gain_hyst_code;
    case (settings.hyst_code)
      2'h0: decoded.hyst_half_db = 4'h2;
      2'h1: decoded.hyst_half_db = 4'h4;
      2'h2: decoded.hyst_half_db = 4'h8;
      default: decoded.hyst_half_db = 4'h0;
    endcase
    decoded.hyst_on = (settings.hyst_code != 2'h3);
    decoded.noise_gate_on = (settings.noise_code != 5'h00);
    // -30 dB at code 1, 2 dB lower per step
    decoded.noise_neg_db = decoded.noise_gate_on ?
      8'(8'h1c + {2'h0, settings.noise_code, 1'b0}) : 8'h00;
  end
endmodule : agc_setting_decode
`default_nettype wire

// ### rtl/agc_control_status_regs.sv
// Purpose: record-path gain control registers on classic Wishbone
// Assumes: single clock, synchronous reset, inputs synchronous
// Notes: byte address is four times the register index
// Operation
// - left gain readback is read-only 8-bit two's complement, -12 to 58 dB
// - left gain readback resets to zero, meaning 0.0 dB
// - top bit of first right register enables gain control, resets clear
// - 3-bit target field codes 0-7 select -5.5 to -24.0 dBFS, resets 0
// - 2-bit gain hysteresis: off, 0.5, 1.0, 1.5 dB
// - 2-bit hysteresis: 1, 2, 4 dB or off, resets 0
// - 5-bit noise threshold: zero disables, else -30 down to -90 dB
// - reserved bits read zero; software writes zero there
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "agc_regs_defines.svh"
module agc_control_status_regs
  import agc_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] left_gain_in,
  input wire logic left_gain_valid,
  output right_settings_type settings,
  output right_decoded_type decoded
);
  // =====================================================
  // storage
  logic [7:0] left_gain;
  logic [7:0] right_first;
  logic [7:0] right_second;
  right_decoded_type next_decoded;
  right_settings_type next_settings;
  logic req;
  logic wr_low;
  logic [7:0] left_clamped;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_low = req && wb_we_i && wb_sel_i[0];

  // =====================================================
  // bus ack, one cycle per access
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= req;
    end
  end

  // read data; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      if (req && !wb_we_i) begin
        if (wb_adr_i == {`LEFT_GAIN_IDX, 2'h0}) begin
          wb_dat_o <= {24'h000000, left_gain};
        end else if (wb_adr_i == {`RIGHT_FIRST_IDX, 2'h0}) begin
          wb_dat_o <= {24'h000000, right_first & `RIGHT_FIRST_MASK};
        end else if (wb_adr_i == {`RIGHT_SECOND_IDX, 2'h0}) begin
          wb_dat_o <= {24'h000000, right_second & `RIGHT_SECOND_MASK};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // =====================================================
  // left gain: hardware fed, clamped to legal span, writes ignored
  always_comb begin
    if ($signed(left_gain_in) < $signed(`GAIN_MIN_CODE)) begin
      left_clamped = `GAIN_MIN_CODE;
    end else if ($signed(left_gain_in) > $signed(`GAIN_MAX_CODE)) begin
      left_clamped = `GAIN_MAX_CODE;
    end else begin
      left_clamped = left_gain_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      left_gain <= `LEFT_GAIN_RESET;
    end else if (clk_en && left_gain_valid) begin
      left_gain <= left_clamped;
    end
  end

  // =====================================================
  // right control registers; reserved bits never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      right_first <= `RIGHT_FIRST_RESET;
    end else if (clk_en && wr_low && wb_adr_i == {`RIGHT_FIRST_IDX, 2'h0}) begin
      right_first <= wb_dat_i[7:0] & `RIGHT_FIRST_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      right_second <= `RIGHT_SECOND_RESET;
    end else if (clk_en && wr_low && wb_adr_i == {`RIGHT_SECOND_IDX, 2'h0}) begin
      right_second <= wb_dat_i[7:0] & `RIGHT_SECOND_MASK;
    end
  end

  // =====================================================
  // settings out to gain engine, registered
  always_comb begin
    next_settings.enable = right_first[`ENABLE_BIT];
    next_settings.target_code = right_first[`TARGET_MSB:`TARGET_LSB];
    next_settings.gain_hyst_code = right_first[`GAIN_HYST_MSB:`GAIN_HYST_LSB];
    next_settings.hyst_code = right_second[`HYST_MSB:`HYST_LSB];
    next_settings.noise_code = right_second[`NOISE_MSB:`NOISE_LSB];
  end

  agc_setting_decode decoder (
    .settings(next_settings),
    .decoded(next_decoded)
  );

  // one cycle behind the register so outputs come from flops
  always_ff @(posedge clk) begin
    if (srst) begin
      settings <= '0;
      decoded <= '0;
    end else if (clk_en) begin
      settings <= next_settings;
      decoded <= next_decoded;
    end
  end

  // =====================================================
  // checks: sequences and properties
  // srst in antecedents too: a reset edge would otherwise start a false attempt
  sequence wr_first_s;
    !srst && clk_en && wr_low && wb_adr_i == {`RIGHT_FIRST_IDX, 2'h0};
  endsequence

  sequence settle_s;
    clk_en && !srst;
  endsequence

  sequence reset_release_s;
    srst ##1 (!srst && clk_en);
  endsequence

  // settings lag the register by one enabled edge
  property enable_follows_p;
    @(posedge clk) disable iff (srst)
      wr_first_s ##1 settle_s |=> settings.enable == $past(wb_dat_i[7], 2);
  endproperty

  // =====================================================
  // checks: registers and decode
  reset_clear_a: assert property (@(posedge clk) srst |=> (left_gain == 8'h00 && right_first == 8'h00))
    else $error("registers not cleared by reset");
  gain_span_a: assert property (@(posedge clk) disable iff (srst)
      $signed(left_gain) >= -24 && $signed(left_gain) <= 116)
    else $error("left gain out of span");
  left_capture_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && left_gain_valid && $signed(left_gain_in) >= -24 && $signed(left_gain_in) <= 116
      |=> left_gain == $past(left_gain_in))
    else $error("left gain not captured");
  reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
      right_first[3:2] == 2'h0 && right_second[0] == 1'b0)
    else $error("reserved bit set");
  enable_write_a: assert property (@(posedge clk) disable iff (srst)
      wr_first_s |=> right_first[7] == $past(wb_dat_i[7]))
    else $error("enable bit not written");
  enable_follows_a: assert property (enable_follows_p)
    else $error("enable output did not follow write");
  reset_target_a: assert property (@(posedge clk) reset_release_s |=> decoded.target_half_db == 6'h0b)
    else $error("target level wrong after reset");
  target_map_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && right_first[6:4] == 3'h6 |=> decoded.target_half_db == 6'h28)
    else $error("target code six mapped wrong");
  target_low_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && right_first[6:4] == 3'h5 |=> decoded.target_half_db == 6'h22)
    else $error("target code five mapped wrong");
  gain_hyst_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en |=> decoded.gain_hyst_half_db == $past(right_first[1:0]))
    else $error("gain hysteresis mismatch");
  hyst_off_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && right_second[7:6] == 2'h3 |=> !decoded.hyst_on && decoded.hyst_half_db == 4'h0)
    else $error("hysteresis not disabled");
  noise_first_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && right_second[5:1] == 5'h01 |=> decoded.noise_neg_db == 8'd30)
    else $error("noise threshold start wrong");
  noise_range_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && right_second[5:1] == 5'h1f |=> decoded.noise_neg_db == 8'd90)
    else $error("noise threshold end wrong");
  noise_off_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && right_second[5:1] == 5'h00 |=> !decoded.noise_gate_on && decoded.noise_neg_db == 8'h00)
    else $error("noise gate not disabled");
  freeze_hold_a: assert property (@(posedge clk) disable iff (srst)
      !srst && !clk_en |=> $stable(left_gain) && $stable(right_first) && $stable(right_second))
    else $error("state moved while clock enable low");

  // =====================================================
  // checks: bus answer and read data
  ack_answer_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  read_left_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && req && !wb_we_i && wb_adr_i == {`LEFT_GAIN_IDX, 2'h0}
      |=> wb_dat_o == {24'h000000, $past(left_gain)})
    else $error("left gain read wrong");
  read_reserved_a: assert property (@(posedge clk) disable iff (srst)
      !srst && clk_en && req && !wb_we_i && wb_adr_i == {`RIGHT_FIRST_IDX, 2'h0}
      |=> wb_dat_o[31:8] == 24'h000000 && wb_dat_o[3:2] == 2'h0 && wb_dat_o[7] == $past(right_first[7]))
    else $error("first register read wrong");
endmodule : agc_control_status_regs
`default_nettype wire

// ### test/agc_control_status_regs_tb.sv
// Purpose: self-checking bench for the gain control register bank
// Assumes: classic Wishbone, byte address is four times the index
// Notes: settings and decoded are looked at two edges after a write
`timescale 1ns/1ns
`default_nettype none
`include "agc_regs_defines.svh"
module agc_control_status_regs_tb
  import agc_regs_pkg::*;
;
  // ==========================================
  // signals and design
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] left_gain_in = 8'h00;
  logic left_gain_valid = 1'b0;
  right_settings_type settings;
  right_decoded_type decoded;
  int error_cnt = 0;
  int check_count = 0;
  localparam logic [9:0] left_adr = {`LEFT_GAIN_IDX, 2'b00};
  localparam logic [9:0] first_adr = {`RIGHT_FIRST_IDX, 2'b00};
  localparam logic [9:0] second_adr = {`RIGHT_SECOND_IDX, 2'b00};
  always #25 clk = ~clk;
  agc_control_status_regs DUT (.clk(clk), .srst(srst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .left_gain_in(left_gain_in),
    .left_gain_valid(left_gain_valid), .settings(settings), .decoded(decoded));
  // ==========================================
  // shared tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // upper data bytes set to ones so stray use of them shows up
  task wb_cycle(input logic we, input logic [9:0] adr, input logic [7:0] wd, input logic [3:0] sel,
    output logic [31:0] rd);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'hffffff, wd};
    // no local limit; a hung wait is ended by the watchdog
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle
  task wr(input logic [9:0] adr, input logic [7:0] wd, input logic [3:0] sel);
    logic [31:0] rd;
    wb_cycle(1'b1, adr, wd, sel, rd);
    repeat (2) @(posedge clk);
    #1;
  endtask : wr
  task rd_check(input string name, input logic [9:0] adr, input logic [7:0] exp);
    logic [31:0] rd;
    wb_cycle(1'b0, adr, 8'h00, 4'hf, rd);
    check(name, rd, {24'h000000, exp});
  endtask : rd_check
  // ==========================================
  // scenarios
  task test_reset;
    rd_check("left gain reset", left_adr, 8'h00);
    rd_check("first reg reset", first_adr, 8'h00);
    rd_check("second reg reset", second_adr, 8'h00);
    check("settings reset", {19'h0, settings}, 32'h0);
    check("target level reset", decoded.target_half_db, 6'd11);
  endtask : test_reset
  task automatic test_left_gain;
    logic [7:0] vin [5] = '{8'he8, 8'h75, 8'h80, 8'h00, 8'h74};
    logic [7:0] vexp [5] = '{8'he8, 8'h74, 8'he8, 8'h00, 8'h74};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      left_gain_in <= vin[i];
      left_gain_valid <= 1'b1;
      @(posedge clk);
      left_gain_valid <= 1'b0;
      rd_check("left gain", left_adr, vexp[i]);
    end
    wr(left_adr, 8'h2a, 4'h1);
    rd_check("left gain after write", left_adr, 8'h74);
  endtask : test_left_gain
  task automatic test_first;
    logic [5:0] tgt [8] = '{6'd11, 6'd16, 6'd20, 6'd24, 6'd28, 6'd34, 6'd40, 6'd48};
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      // software writes only zeros into the reserved bits
      v = {1'b1, i[2:0], 2'b00, i[1:0]};
      wr(first_adr, v, 4'h1);
      check("enable", settings.enable, 1'b1);
      check("target code", settings.target_code, i[2:0]);
      check("target level", decoded.target_half_db, tgt[i]);
      check("gain hyst", decoded.gain_hyst_half_db, i[1:0]);
      rd_check("first reg", first_adr, v & 8'hf3);
    end
    wr(first_adr, 8'h00, 4'h1);
    check("disable", settings.enable, 1'b0);
  endtask : test_first
  task automatic test_second;
    logic [4:0] nz [4] = '{5'd0, 5'd1, 5'd15, 5'd31};
    logic [3:0] hy [3] = '{4'd2, 4'd4, 4'd8};
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], nz[i], 1'b0};
      wr(second_adr, v, 4'h1);
      check("hyst on", decoded.hyst_on, i != 3);
      if (i != 3) check("hyst level", decoded.hyst_half_db, hy[i]);
      check("gate on", decoded.noise_gate_on, i != 0);
      if (i != 0) check("noise level", decoded.noise_neg_db, 8'd28 + 2 * nz[i]);
      rd_check("second reg", second_adr, v & 8'hfe);
    end
  endtask : test_second
  task test_refused;
    wr(first_adr, 8'h51, 4'h1);
    wr(first_adr, 8'hf3, 4'he);
    rd_check("first reg lane off", first_adr, 8'h51);
    wr(10'h100, 8'hff, 4'h1);
    rd_check("unmapped read", 10'h100, 8'h00);
    rd_check("first reg kept", first_adr, 8'h51);
  endtask : test_refused
  // clock enable low: a valid gain code must not be taken
  task test_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    left_gain_in <= 8'h10;
    left_gain_valid <= 1'b1;
    repeat (3) @(posedge clk);
    left_gain_valid <= 1'b0;
    clk_en <= 1'b1;
    rd_check("left gain frozen", left_adr, 8'h74);
  endtask : test_freeze
  // reset in mid run with every register holding a nonzero value
  task test_mid_reset;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd_check("first reg after reset", first_adr, 8'h00);
    rd_check("second reg after reset", second_adr, 8'h00);
    rd_check("left gain after reset", left_adr, 8'h00);
    check("settings after reset", {19'h0, settings}, 32'h0);
    check("target level after reset", decoded.target_half_db, 6'd11);
  endtask : test_mid_reset
  // ==========================================
  // run control
  task final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    test_reset();
    test_left_gain();
    test_first();
    test_second();
    test_refused();
    test_freeze();
    test_mid_reset();
    final_report();
  end
  // whole run needs a few hundred cycles; ample margin
  initial begin
    #(20000 * 50);
    error_cnt++;
    final_report();
  end
endmodule : agc_control_status_regs_tb
`default_nettype wire
